//--- src/uart_flow_defs.svh
// register offsets, field positions, reset values and fifo trigger tables
`ifndef UART_FLOW_DEFS_SVH
`define UART_FLOW_DEFS_SVH
// ----------------------------------------------------------------
// register byte offsets on the avalon slave
// ----------------------------------------------------------------
`define OFS_ENH_FEATURE 6'h00
`define OFS_DIV_LOW 6'h04
`define OFS_DIV_HIGH 6'h08
`define OFS_DIV_FRAC 6'h0C
`define OFS_FLOW_THRESH 6'h10
`define OFS_TRIG_LEVEL 6'h14
`define OFS_FIFO_READY 6'h18
`define OFS_INT_ENABLE 6'h1C
`define OFS_FIFO_CTRL 6'h20
`define OFS_MODEM_CTRL 6'h24
`define OFS_XOFF2_CHAR 6'h28
`define OFS_IRQ_STATUS 6'h2C
`define OFS_IRQ_MASK 6'h30
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ENH_WRITE_EN 4
`define ENH_SPECIAL 5
`define ENH_AUTO_RTS 6
`define ENH_AUTO_CTS 7
`define FRAC_DIV8 7
`define INT_EN_SLEEP 4
`define MODEM_READY_EN 2
`define MODEM_LOOPBACK 4
`define MODEM_THRESH_ACCESS 6
`define FIFO_READY_TX 0
`define FIFO_READY_RX 4
`define IRQ_SPECIAL 0
`define IRQ_RTS_HALT 1
`define IRQ_CTS_HALT 2
`define IRQ_TX_READY 3
`define IRQ_RX_READY 4
// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define REG_RESET 8'h00
`define TRIG_STEP 8'h08
`define FIFO_DEPTH 8'h80
// fifo-control trigger tables, selected by a two-bit field
`define TX_TRIG_TABLE {8'h38, 8'h20, 8'h10, 8'h08}
`define RX_TRIG_TABLE {8'h3C, 8'h38, 8'h10, 8'h08}
`endif

//--- src/uart_flow_pkg.sv
// types shared by the uart flow and fifo configuration block
package uart_flow_pkg;
   // fifo fill state reported by the surrounding uart
   typedef struct packed {
      logic [7:0] rx_count;
      logic [7:0] tx_count;
      logic rx_timeout;
   } fifo_status_type;
   // one received character as it enters the receive fifo
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rx_char_type;
   // avalon handshake phase
   typedef enum logic {bus_idle, bus_ack} bus_state_type;
endpackage

//--- src/uart_baud_gen.sv
// fractional baud generator with 16x or 8x oversampling
`timescale 1ns/1ps
module uart_baud_gen (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [15:0] divisor,
   input wire logic [5:0] fraction,
   input wire logic div8,
   output logic sample_tick,
   output logic baud_tick
);
   logic [15:0] cnt_q;
   logic [5:0] acc_q;
   logic [3:0] os_q;
   logic [6:0] sum;
   logic [3:0] os_last;

   // fraction accumulates in 64ths; a carry stretches one period by a cycle
   assign sum = {1'b0, acc_q} + {1'b0, fraction};
   assign os_last = div8 ? 4'h7 : 4'hF;

   // ----------------------------------------------------------------
   // sample clock divider
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= 16'h0000;
         acc_q <= 6'h00;
         sample_tick <= 1'b0;
      end else if (ce) begin
         sample_tick <= 1'b0;
         if (divisor == 16'h0000) begin
            cnt_q <= 16'h0000; // a zero divisor stops the generator
         end else if (cnt_q == 16'h0000) begin
            sample_tick <= 1'b1;
            acc_q <= sum[5:0];
            cnt_q <= divisor - 16'h0001 + {15'h0000, sum[6]};
         end else begin
            cnt_q <= cnt_q - 16'h0001;
         end
      end
   end

   // oversampling divider, 16 or 8 sample ticks per bit
   always_ff @(posedge clock) begin
      if (rst) begin
         os_q <= 4'h0;
         baud_tick <= 1'b0;
      end else if (ce) begin
         baud_tick <= 1'b0;
         if (sample_tick) begin
            if (os_q >= os_last) begin
               os_q <= 4'h0;
               baud_tick <= 1'b1;
            end else begin
               os_q <= os_q + 4'h1;
            end
         end
      end
   end
endmodule // uart_baud_gen

//--- src/uart_flow_cfg.sv
// uart enhanced-feature, divisor, threshold and fifo-ready register block
// Operation
// - software flow mode taken from enhanced-feature bits 3:0
// - enhanced bit 4 opens upper enable, fifo 5:4, modem 7:5 writes and enhanced functions
// - special detect compares received characters with xoff2 and flags a match
// - auto rts drives rts high at halt level, low at restore level
// - auto cts halts transmission while cts input is high
// - sixteen-bit divisor held as high and low byte registers
// - fraction register low six bits add x/64 to the divisor
// - fraction bit 7 picks divide-by-8, else 16; bit 6 reserved
// - divisor registers writable only while sleep enable is clear
// - threshold register: halt level bits 3:0, restore bits 7:4, steps of 8
// - threshold and trigger writes need enhanced bit 4 and modem-control bit 6
// - trigger register: tx spaces bits 3:0, rx chars bits 7:4, value N*8
// - a zero trigger field falls back to the fifo-control selection
// - ready bit 0 set while tx free spaces reach the tx trigger
// - ready bit 4 set when rx count exceeds trigger or timeout; others zero
// - fifo-ready reads only when selected, modem-control bit 2 set, no loopback
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "uart_flow_defs.svh"
module uart_flow_cfg #(
   parameter logic [7:0] FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire uart_flow_pkg::fifo_status_type fifo_status,
   input wire uart_flow_pkg::rx_char_type rx_char,
   input wire logic cts_n,
   output logic rts_n,
   output logic tx_halt,
   output logic special_char,
   output logic [3:0] sw_flow_mode,
   output logic tx_ready,
   output logic rx_ready,
   output logic sample_tick,
   output logic baud_tick,
   output logic irq
);
   import uart_flow_pkg::*;

   // ----------------------------------------------------------------
   // registers and decode helpers
   // ----------------------------------------------------------------
   bus_state_type state_q;
   logic [7:0] enh_q, div_lo_q, div_hi_q, frac_q, thresh_q, trig_q;
   logic [7:0] int_enable_q, fifo_ctrl_q, modem_ctrl_q, xoff2_q, irq_stat_q, irq_mask_q;
   logic [7:0] tx_trig, rx_trig, tx_free, ready_val, irq_set;
   logic wr_fire, rd_take, enh, thresh_access, div_open, tx_ready_prev, rx_ready_prev;

   // table lookup used for both fifo-control trigger selections
   function automatic logic [7:0] pick_level(input logic [31:0] table_v, input logic [1:0] sel);
      pick_level = table_v[8*sel +: 8];
   endfunction

   assign enh = enh_q[`ENH_WRITE_EN];
   assign thresh_access = enh && modem_ctrl_q[`MODEM_THRESH_ACCESS];
   assign div_open = !int_enable_q[`INT_EN_SLEEP];
   // a write lands only on the edge that the master sees waitrequest low
   assign wr_fire = write && (state_q == bus_ack) && byteenable[0];
   assign rd_take = read && (state_q == bus_idle);

   // ----------------------------------------------------------------
   // avalon handshake: one wait cycle, then answer
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= bus_idle;
         waitrequest <= 1'b1;
      end else if (ce) begin
         if ((read || write) && state_q == bus_idle) begin
            state_q <= bus_ack;
            waitrequest <= 1'b0;
         end else begin
            state_q <= bus_idle;
            waitrequest <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         enh_q <= `REG_RESET;
         div_lo_q <= `REG_RESET;
         div_hi_q <= `REG_RESET;
         frac_q <= `REG_RESET;
         thresh_q <= `REG_RESET;
         trig_q <= `REG_RESET;
         int_enable_q <= `REG_RESET;
         fifo_ctrl_q <= `REG_RESET;
         modem_ctrl_q <= `REG_RESET;
         xoff2_q <= `REG_RESET;
         irq_mask_q <= `REG_RESET;
      end else if (ce && wr_fire) begin
         // address decoding; unmapped offsets are silently dropped
         if (address == `OFS_ENH_FEATURE) begin
            enh_q <= writedata[7:0];
         end else if (address == `OFS_DIV_LOW) begin
            if (div_open) div_lo_q <= writedata[7:0];
         end else if (address == `OFS_DIV_HIGH) begin
            if (div_open) div_hi_q <= writedata[7:0];
         end else if (address == `OFS_DIV_FRAC) begin
            if (div_open) frac_q <= {writedata[7], 1'b0, writedata[5:0]};
         end else if (address == `OFS_FLOW_THRESH) begin
            if (thresh_access) thresh_q <= writedata[7:0];
         end else if (address == `OFS_TRIG_LEVEL) begin
            if (thresh_access) trig_q <= writedata[7:0];
         end else if (address == `OFS_INT_ENABLE) begin
            // upper enable bits only move while enhanced writes are open
            int_enable_q <= {enh ? writedata[7:4] : int_enable_q[7:4], writedata[3:0]};
         end else if (address == `OFS_FIFO_CTRL) begin
            fifo_ctrl_q <= {writedata[7:6], enh ? writedata[5:4] : fifo_ctrl_q[5:4],
                            writedata[3:0]};
         end else if (address == `OFS_MODEM_CTRL) begin
            modem_ctrl_q <= {enh ? writedata[7:5] : modem_ctrl_q[7:5], writedata[4:0]};
         end else if (address == `OFS_XOFF2_CHAR) begin
            xoff2_q <= writedata[7:0];
         end else if (address == `OFS_IRQ_MASK) begin
            irq_mask_q <= writedata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // trigger level selection and fifo readiness
   // ----------------------------------------------------------------
   // a zero field hands the choice back to the fifo-control register
   always_comb begin
      tx_trig = (trig_q[3:0] == 4'h0) ? pick_level(`TX_TRIG_TABLE, fifo_ctrl_q[5:4])
                                      : {1'b0, trig_q[3:0], 3'b000};
      rx_trig = (trig_q[7:4] == 4'h0) ? pick_level(`RX_TRIG_TABLE, fifo_ctrl_q[7:6])
                                      : {1'b0, trig_q[7:4], 3'b000};
   end

   // free space never underflows even if the count overshoots
   assign tx_free = (fifo_status.tx_count >= FIFO_DEPTH) ? 8'h00
                    : FIFO_DEPTH - fifo_status.tx_count;

   // readiness flags held in flops so readback and pins agree
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_ready <= 1'b0;
         rx_ready <= 1'b0;
         tx_ready_prev <= 1'b0;
         rx_ready_prev <= 1'b0;
      end else if (ce) begin
         tx_ready <= (tx_free >= tx_trig);
         rx_ready <= (fifo_status.rx_count > rx_trig) || fifo_status.rx_timeout;
         tx_ready_prev <= tx_ready;
         rx_ready_prev <= rx_ready;
      end
   end

   // ----------------------------------------------------------------
   // flow control outputs
   // ----------------------------------------------------------------
   // halt above restore is trusted; equal or inverted levels may toggle rts
   always_ff @(posedge clock) begin
      if (rst) begin
         rts_n <= 1'b0;
         tx_halt <= 1'b0;
         sw_flow_mode <= 4'h0;
      end else if (ce) begin
         sw_flow_mode <= enh ? enh_q[3:0] : 4'h0;
         tx_halt <= enh && enh_q[`ENH_AUTO_CTS] && cts_n;
         if (!(enh && enh_q[`ENH_AUTO_RTS])) begin
            rts_n <= 1'b0;
         end else if (fifo_status.rx_count >= {1'b0, thresh_q[3:0], 3'b000}) begin
            rts_n <= 1'b1;
         end else if (fifo_status.rx_count <= {1'b0, thresh_q[7:4], 3'b000}) begin
            rts_n <= 1'b0;
         end
      end
   end

   // special character flag: a fresh match wins over a clearing write
   always_ff @(posedge clock) begin
      if (rst) begin
         special_char <= 1'b0;
      end else if (ce) begin
         if (rx_char.valid && enh && enh_q[`ENH_SPECIAL] && rx_char.data == xoff2_q) begin
            special_char <= 1'b1;
         end else if (wr_fire && address == `OFS_IRQ_STATUS
                      && writedata[`IRQ_SPECIAL]) begin
            special_char <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, mask and output
   // ----------------------------------------------------------------
   always_comb begin
      irq_set = 8'h00;
      irq_set[`IRQ_SPECIAL] = rx_char.valid && enh && enh_q[`ENH_SPECIAL]
                              && rx_char.data == xoff2_q;
      irq_set[`IRQ_RTS_HALT] = enh && enh_q[`ENH_AUTO_RTS] && !rts_n
                               && fifo_status.rx_count >= {1'b0, thresh_q[3:0], 3'b000};
      irq_set[`IRQ_CTS_HALT] = enh && enh_q[`ENH_AUTO_CTS] && cts_n && !tx_halt;
      irq_set[`IRQ_TX_READY] = tx_ready && !tx_ready_prev;
      irq_set[`IRQ_RX_READY] = rx_ready && !rx_ready_prev;
   end

   // write one to clear; a simultaneous event keeps its bit set
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_stat_q <= 8'h00;
         irq <= 1'b0;
      end else if (ce) begin
         if (wr_fire && address == `OFS_IRQ_STATUS) begin
            irq_stat_q <= (irq_stat_q & ~writedata[7:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // fifo-ready reads zero unless enabled and out of loopback
   always_comb begin
      ready_val = 8'h00;
      if (modem_ctrl_q[`MODEM_READY_EN] && !modem_ctrl_q[`MODEM_LOOPBACK]) begin
         ready_val[`FIFO_READY_TX] = tx_ready;
         ready_val[`FIFO_READY_RX] = rx_ready;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         readdata <= 32'h0000_0000;
      end else if (ce && rd_take) begin
         if (address == `OFS_ENH_FEATURE) begin
            readdata <= {24'h00_0000, enh_q};
         end else if (address == `OFS_DIV_LOW) begin
            readdata <= {24'h00_0000, div_lo_q};
         end else if (address == `OFS_DIV_HIGH) begin
            readdata <= {24'h00_0000, div_hi_q};
         end else if (address == `OFS_DIV_FRAC) begin
            readdata <= {24'h00_0000, frac_q};
         end else if (address == `OFS_FLOW_THRESH) begin
            readdata <= {24'h00_0000, thresh_q};
         end else if (address == `OFS_TRIG_LEVEL) begin
            readdata <= {24'h00_0000, trig_q};
         end else if (address == `OFS_FIFO_READY) begin
            readdata <= {24'h00_0000, ready_val};
         end else if (address == `OFS_INT_ENABLE) begin
            readdata <= {24'h00_0000, int_enable_q};
         end else if (address == `OFS_FIFO_CTRL) begin
            readdata <= {24'h00_0000, fifo_ctrl_q};
         end else if (address == `OFS_MODEM_CTRL) begin
            readdata <= {24'h00_0000, modem_ctrl_q};
         end else if (address == `OFS_XOFF2_CHAR) begin
            readdata <= {24'h00_0000, xoff2_q};
         end else if (address == `OFS_IRQ_STATUS) begin
            readdata <= {24'h00_0000, irq_stat_q};
         end else if (address == `OFS_IRQ_MASK) begin
            readdata <= {24'h00_0000, irq_mask_q};
         end else begin
            readdata <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // baud generator
   // ----------------------------------------------------------------
   uart_baud_gen u_baud (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .divisor({div_hi_q, div_lo_q}),
      .fraction(frac_q[5:0]),
      .div8(frac_q[`FRAC_DIV8]),
      .sample_tick(sample_tick),
      .baud_tick(baud_tick)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_div_sleep_lock: assert property (ce && int_enable_q[`INT_EN_SLEEP]
         |=> $stable({div_hi_q, div_lo_q, frac_q}))
      else $error("divisor changed while sleep enabled");
   a_thresh_gate: assert property (ce && !thresh_access |=> $stable(thresh_q) && $stable(trig_q))
      else $error("threshold or trigger written while locked");
   a_cts_halt: assert property (ce && enh && enh_q[`ENH_AUTO_CTS] && cts_n |=> tx_halt)
      else $error("transmit not halted on high cts");
   a_rts_halt_level: assert property (ce && enh && enh_q[`ENH_AUTO_RTS]
         && fifo_status.rx_count >= {1'b0, thresh_q[3:0], 3'b000} |=> rts_n)
      else $error("rts not raised at halt level");
   a_ready_gated: assert property (ce && rd_take && address == `OFS_FIFO_READY
         && !modem_ctrl_q[`MODEM_READY_EN] |=> readdata == 32'h0000_0000)
      else $error("fifo ready visible while disabled");
   a_ready_zero_bits: assert property (ready_val[3:1] == 3'b000 && ready_val[7:5] == 3'b000)
      else $error("unused ready bits set");
   a_tx_trig_fallback: assert property (trig_q[3:0] == 4'h0 && ce
         |=> tx_ready == ($past(tx_free) >= pick_level(`TX_TRIG_TABLE, $past(fifo_ctrl_q[5:4]))))
      else $error("tx trigger fallback wrong");
   a_special_set: assert property (ce && irq_set[`IRQ_SPECIAL]
         |=> special_char && irq_stat_q[`IRQ_SPECIAL])
      else $error("special match lost");
   a_enable_upper_lock: assert property (ce && !enh
         |=> $stable(int_enable_q[7:4]) && $stable(fifo_ctrl_q[5:4]) && $stable(modem_ctrl_q[7:5]))
      else $error("upper enable bits moved while locked");
   a_frac_reserved: assert property (frac_q[6] == 1'b0)
      else $error("reserved fraction bit set");
   a_sw_mode: assert property (ce |=> sw_flow_mode == ($past(enh) ? $past(enh_q[3:0]) : 4'h0))
      else $error("software flow mode mismatch");
   a_bus_answer: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
      else $error("no answer one cycle after request");

   c_rts_raise: cover property (!rts_n ##1 rts_n);
   c_write_fire: cover property (wr_fire && address == `OFS_FLOW_THRESH && thresh_access);
   c_irq_out: cover property (!irq ##1 irq);
   c_baud: cover property (baud_tick);
endmodule // uart_flow_cfg

//--- verif/uart_peer.sv
// remote serial peer: sends received characters and drives clear-to-send
`timescale 1ns/1ps
module uart_peer (
   input wire logic clock,
   input wire logic rst,
   input wire logic rts_n,
   input wire logic go,
   input wire logic [7:0] char_in,
   input wire logic stall,
   output uart_flow_pkg::rx_char_type rx_char,
   output logic cts_n
);
   import uart_flow_pkg::*;
   // one character per go pulse, held back while the device asks us to stop
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_char <= '0;
      end else if (go && !rts_n) begin
         rx_char <= {1'b1, char_in};
      end else begin
         // idle data keeps toggling so a stale byte never looks like a match
         rx_char <= {1'b0, ~rx_char.data};
      end
   end
   // stall holds clear-to-send inactive, asking the device to halt
   assign cts_n = stall;
endmodule // uart_peer

//--- verif/uart_flow_cfg_test.sv
// self-checking bench for the uart flow and fifo configuration block
`timescale 1ns/1ps
`include "uart_flow_defs.svh"
module uart_flow_cfg_test;
   import uart_flow_pkg::*;
   logic clock, rst, ce, read, write, waitrequest, cts_n, rts_n, tx_halt, special_char;
   logic tx_ready, rx_ready, sample_tick, baud_tick, irq, go, stall;
   logic [5:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable, sw_flow_mode;
   logic [7:0] char_in, q;
   fifo_status_type fifo_status;
   rx_char_type rx_char;
   int n_fail, checked, cycles, nsmp, nbaud, trig, fctl, rx, tx, st;
   int txt[4] = '{8, 16, 32, 56};
   int rxt[4] = '{8, 16, 56, 60};
   int seq[8] = '{31, 32, 20, 17, 16, 40, 33, 0};

   uart_flow_cfg i_dut (.clock(clock), .rst(rst), .ce(ce), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .fifo_status(fifo_status), .rx_char(rx_char), .cts_n(cts_n),
      .rts_n(rts_n), .tx_halt(tx_halt), .special_char(special_char),
      .sw_flow_mode(sw_flow_mode), .tx_ready(tx_ready), .rx_ready(rx_ready),
      .sample_tick(sample_tick), .baud_tick(baud_tick), .irq(irq));
   uart_peer i_peer (.clock(clock), .rst(rst), .rts_n(rts_n), .go(go), .char_in(char_in),
      .stall(stall), .rx_char(rx_char), .cts_n(cts_n));

   // clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         $display("BAD %0t timeout", $time);
         summarize();
      end
   end
   // ticks counted on the falling edge so the count never races the design
   always @(negedge clock) begin
      nsmp += (sample_tick === 1'b1);
      nbaud += (baud_tick === 1'b1);
   end

   // model trigger levels: a zero field falls back to the fifo-control table
   function automatic int ttrig();
      return (trig % 16) ? trig % 16 * 8 : txt[fctl / 16 % 4];
   endfunction
   function automatic int rtrig();
      return (trig / 16) ? trig / 16 * 8 : rxt[fctl / 64];
   endfunction
   task automatic summarize();
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input int e);
      checked++;
      if (g !== e[7:0]) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, g, e[7:0]);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input int d);
      @(posedge clock);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= {24'h00_0000, d[7:0]};
      do @(posedge clock); while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input int d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, input int e);
      bus(1'b0, a, 0);
      chk(q, e);
   endtask
   // new fifo levels, then two edges for the registered flags to follow
   task automatic fs(input int r, input int t, input logic to);
      @(posedge clock);
      fifo_status <= {r[7:0], t[7:0], to};
      repeat (2) @(posedge clock);
   endtask
   task automatic send(input int c);
      @(posedge clock);
      go <= 1'b1;
      char_in <= c[7:0];
      @(posedge clock);
      go <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = '0;
      writedata = '0;
      byteenable = 4'hf;
      fifo_status = '0;
      go = 1'b0;
      stall = 1'b0;
      char_in = '0;
      void'($urandom(91));
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      for (int a = 0; a <= 24; a += 4) rd(a[5:0], 0);
      rd(6'h3C, 0);
      $display("test 1 done");
      // gate closed, then opened
      wr(`OFS_MODEM_CTRL, 8'h40);
      rd(`OFS_MODEM_CTRL, 0);
      wr(`OFS_ENH_FEATURE, 8'h0F);
      repeat (2) @(posedge clock);
      chk(sw_flow_mode, 0);
      wr(`OFS_ENH_FEATURE, 8'h1A);
      wr(`OFS_FLOW_THRESH, 8'h24);
      rd(`OFS_FLOW_THRESH, 0);
      chk(sw_flow_mode, 10);
      wr(`OFS_MODEM_CTRL, 8'h44);
      rd(`OFS_MODEM_CTRL, 8'h44);
      rx = 1 + $urandom % 15;
      tx = $urandom % rx;
      wr(`OFS_FLOW_THRESH, tx * 16 + rx);
      rd(`OFS_FLOW_THRESH, tx * 16 + rx);
      $display("test 2 done");
      // trigger levels against the fifo-ready flags, random levels every third pass, boundaries on the rest
      for (int i = 0; i < 24; i++) begin
         if (i % 6 == 0) begin
            trig = (i == 0) ? 0 : $urandom % 256;
            fctl = $urandom % 256 & 8'hF0;
            wr(`OFS_TRIG_LEVEL, trig);
            wr(`OFS_FIFO_CTRL, fctl);
            rd(`OFS_TRIG_LEVEL, trig);
         end
         rx = (i % 3 == 0) ? $urandom % 129 : rtrig() + i % 3 - 1;
         tx = (i % 3 == 0) ? $urandom % 129 : 127 - ttrig() + i % 3;
         fs(rx, tx, i % 5 == 0);
         st = (128 - tx >= ttrig()) + 16 * (rx > rtrig() || i % 5 == 0);
         chk(tx_ready, st % 2);
         chk(rx_ready, st / 16);
         rd(`OFS_FIFO_READY, st);
      end
      wr(`OFS_MODEM_CTRL, 8'h54);
      rd(`OFS_FIFO_READY, 0);
      wr(`OFS_MODEM_CTRL, 8'h40);
      rd(`OFS_FIFO_READY, 0);
      $display("test 3 done");
      // auto request-to-send with hysteresis between 16 and 32
      fs(0, 0, 1'b0);
      wr(`OFS_FLOW_THRESH, 8'h24);
      wr(`OFS_ENH_FEATURE, 8'h50);
      st = 0;
      foreach (seq[k]) begin
         fs(seq[k], 0, 1'b0);
         st = (seq[k] >= 32) ? 1 : (seq[k] <= 16) ? 0 : st;
         chk(rts_n, st);
      end
      // a low clock enable freezes the flow logic even as the fifo fills
      ce <= 1'b0;
      fs(40, 0, 1'b0);
      chk(rts_n, 0);
      ce <= 1'b1;
      repeat (2) @(posedge clock);
      chk(rts_n, 1);
      fs(0, 0, 1'b0);
      // auto clear-to-send, also with the feature gate closed
      for (int k = 0; k < 4; k++) begin
         wr(`OFS_ENH_FEATURE, k == 2 ? 8'h10 : k == 3 ? 8'h80 : 8'h90);
         @(posedge clock);
         stall <= (k != 1);
         repeat (3) @(posedge clock);
         chk(tx_halt, k == 0);
      end
      stall <= 1'b0;
      $display("test 4 done");
      // special character, masked interrupt and write-one clear
      wr(`OFS_ENH_FEATURE, 8'h70);
      byteenable <= 4'hE;
      wr(`OFS_XOFF2_CHAR, 8'h13);
      rd(`OFS_XOFF2_CHAR, 0);
      byteenable <= 4'hF;
      wr(`OFS_XOFF2_CHAR, 8'h13);
      wr(`OFS_IRQ_MASK, 8'h01);
      wr(`OFS_IRQ_STATUS, 8'hFF);
      send(8'h11);
      chk({special_char, irq}, 0);
      send(8'h13);
      chk({special_char, irq}, 3);
      wr(`OFS_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clock);
      chk(irq, 0);
      rd(`OFS_IRQ_STATUS, 1);
      wr(`OFS_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge clock);
      chk(special_char, 0);
      $display("test 5 done");
      // divisor 4 with divide-by-8: a sample every 4 cycles, a bit every 32
      wr(`OFS_DIV_LOW, 4);
      wr(`OFS_DIV_FRAC, 8'h80);
      repeat (64) @(posedge clock);
      rx = nsmp;
      tx = nbaud;
      repeat (640) @(posedge clock);
      chk(nsmp - rx, 160);
      chk(nbaud - tx, 20);
      rx = $urandom % 256;
      tx = $urandom % 256;
      wr(`OFS_DIV_LOW, rx);
      wr(`OFS_DIV_HIGH, tx);
      wr(`OFS_DIV_FRAC, tx | 8'h40);
      rd(`OFS_DIV_LOW, rx);
      rd(`OFS_DIV_HIGH, tx);
      rd(`OFS_DIV_FRAC, tx & 8'hBF);
      wr(`OFS_INT_ENABLE, 8'h10);
      wr(`OFS_DIV_LOW, ~rx);
      rd(`OFS_DIV_LOW, rx);
      $display("test 6 done");
      summarize();
   end
endmodule // uart_flow_cfg_test
